// *** dlb_defines.svh ***
// Offsets, field positions, reset values and pattern timing for the indicator controller.
// Assumes a 100 MHz system clock and an 8-bit I/O register port with byte addresses.
// Summary of operation
// (RULE1) Three 8-bit RW registers at 210H, 211H, 214H; bit0 enable, bits2:1 pattern.
// (RULE2) Diagnostic lamp off while its enable is 0, patterned while 1.
// (RULE3) Lamp pattern: 00 steady, 01 fast flicker, 10 normal flicker, 11 short flicker.
// (RULE4) Buzzer silent while its enable is 0, patterned while 1.
// (RULE5) Buzzer pattern: 00 continuous, 01 short beep, 10 normal beep, 11 long beep.
// (RULE6) User bank bit n drives user lamp n; 1 on, 0 off.
// (RULE7) Periods come from a divided clock; pattern restarts when enable is set.
`ifndef DLB_DEFINES_SVH
`define DLB_DEFINES_SVH

`define DLB_ADDR_W          10
`define DLB_OFS_DIAGNOSTIC_INDICATOR        10'h210
`define DLB_OFS_BUZZ        10'h211
`define DLB_OFS_ULED        10'h214
`define DLB_BIT_EN          0
`define DLB_BIT_PAT_LO      1
`define DLB_BIT_PAT_HI      2
`define DLB_CTRL_MASK       8'h07
`define DLB_RST_CTRL        8'h00
`define DLB_RST_ULED        8'h00

// Time base tick period in us and its cycle count at 100 MHz
`define DLB_CLK_MHZ         100
`define DLB_TICK_US         1000
`define DLB_TICK_CYC        (`DLB_TICK_US * `DLB_CLK_MHZ)
`define DLB_TICK_W          17

// Pattern timing in ms ticks: period and on time
`define DLB_PHASE_W         11
`define DLB_FAST_PER_MS     11'd200
`define DLB_FAST_ON_MS      11'd100
`define DLB_NORM_PER_MS     11'd1000
`define DLB_NORM_ON_MS      11'd500
`define DLB_SHORT_PER_MS    11'd1000
`define DLB_SHORT_ON_MS     11'd100
`define DLB_LONG_PER_MS     11'd2000
`define DLB_LONG_ON_MS      11'd1500

`endif

// *** dlb_pkg.sv ***
// Types shared by the indicator controller.
// Assumes dlb_defines.svh supplies the widths.
`default_nettype none
`include "dlb_defines.svh"
package dlb_pkg;
    typedef struct packed {
        logic                     wr;
        logic                     rd;
        logic [`DLB_ADDR_W-1:0]   addr;
        logic [7:0]               wdata;
    } dlb_io_req_t;

    typedef struct packed {
        logic       diagnostic_indicator_lamp;
        logic       buzzer;
        logic [7:0] user_lamp_bits;
    } dlb_ind_t;

    typedef struct packed {
        logic [`DLB_PHASE_W-1:0] period;
        logic [`DLB_PHASE_W-1:0] on_time;
    } dlb_shape_t;
endpackage : dlb_pkg
`default_nettype wire

// *** dlb_ctrl.sv ***
// Indicator controller: three I/O registers drive diagnostic lamp, buzzer and user lamps.
// Assumes one I/O cycle per strobe, synchronous to sys_clk_i; reads answer next cycle.
`timescale 1ns/1ps
`default_nettype none
`include "dlb_defines.svh"
module dlb_ctrl (
    input  wire logic              sys_clk_i,
    input  wire logic              rst_i,
    input  wire dlb_pkg::dlb_io_req_t io_req_i,
    output var  logic [7:0]        io_rdata_o,
    output var  logic              io_rvalid_o,
    output var  dlb_pkg::dlb_ind_t ind_o
);
    import dlb_pkg::*;

    logic [7:0]              diagnostic_indicator_led_control;
    logic [7:0]              buzzer_control;
    logic [7:0]              user_led_bank;
    logic [2:0]              addr_hit;
    logic                    wr_diagnostic_indicator;
    logic                    wr_buzz;
    logic                    wr_uled;

    logic [`DLB_TICK_W-1:0]  tick_cnt;
    logic                    tick_due;
    logic                    tick;
    logic [`DLB_PHASE_W-1:0] diagnostic_indicator_phase;
    logic [`DLB_PHASE_W-1:0] buzz_phase;
    logic [`DLB_PHASE_W-1:0] next_diagnostic_indicator_phase;
    logic [`DLB_PHASE_W-1:0] next_buzz_phase;
    logic                    diagnostic_indicator_restart;
    logic                    buzz_restart;
    dlb_shape_t              diagnostic_indicator_shape;
    dlb_shape_t              buzz_shape;

    logic                    next_diagnostic_indicator;
    logic                    next_buzz;

    // Address decode shared by the write strobes and the read mux
    function automatic logic [2:0] reg_hit(
        input logic [`DLB_ADDR_W-1:0] addr
    );
        logic [2:0] hit;
        hit    = 3'h0;
        hit[0] = (addr == `DLB_OFS_DIAGNOSTIC_INDICATOR);
        hit[1] = (addr == `DLB_OFS_BUZZ);
        hit[2] = (addr == `DLB_OFS_ULED);
        return hit;
    endfunction : reg_hit

    // Lamp pattern decode; steady on uses period 0
    function automatic dlb_shape_t lamp_shape(
        input logic [1:0] sel
    );
        dlb_shape_t s;
        s = '{period: '0, on_time: '0};
        unique case (sel)
            2'h0: s = '{period: '0, on_time: '0};
            2'h1: s = '{period: `DLB_FAST_PER_MS, on_time: `DLB_FAST_ON_MS};
            2'h2: s = '{period: `DLB_NORM_PER_MS, on_time: `DLB_NORM_ON_MS};
            2'h3: s = '{period: `DLB_SHORT_PER_MS, on_time: `DLB_SHORT_ON_MS};
        endcase
        return s;
    endfunction : lamp_shape

    // Buzzer pattern decode; continuous uses period 0
    function automatic dlb_shape_t beep_shape(
        input logic [1:0] sel
    );
        dlb_shape_t s;
        s = '{period: '0, on_time: '0};
        unique case (sel)
            2'h0: s = '{period: '0, on_time: '0};
            2'h1: s = '{period: `DLB_SHORT_PER_MS, on_time: `DLB_SHORT_ON_MS};
            2'h2: s = '{period: `DLB_NORM_PER_MS, on_time: `DLB_NORM_ON_MS};
            2'h3: s = '{period: `DLB_LONG_PER_MS, on_time: `DLB_LONG_ON_MS};
        endcase
        return s;
    endfunction : beep_shape

    // Period 0 means steady; otherwise on for the first on_time ticks
    function automatic logic shape_out(
        input dlb_shape_t              s,
        input logic [`DLB_PHASE_W-1:0] ph
    );
        return (s.period == '0) ? 1'b1 : (ph < s.on_time);
    endfunction : shape_out

    // Write strobes, one per register
    assign addr_hit = reg_hit(io_req_i.addr);
    assign wr_diagnostic_indicator  = io_req_i.wr && addr_hit[0];
    assign wr_buzz  = io_req_i.wr && addr_hit[1];
    assign wr_uled  = io_req_i.wr && addr_hit[2];

    // Reserved bits are not stored, so they read back as zero
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            diagnostic_indicator_led_control <= `DLB_RST_CTRL;
        end else if (wr_diagnostic_indicator) begin
            diagnostic_indicator_led_control <= io_req_i.wdata & `DLB_CTRL_MASK; // see (RULE1)
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            buzzer_control <= `DLB_RST_CTRL;
        end else if (wr_buzz) begin
            buzzer_control <= io_req_i.wdata & `DLB_CTRL_MASK; // see (RULE1)
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            user_led_bank <= `DLB_RST_ULED;
        end else if (wr_uled) begin
            user_led_bank <= io_req_i.wdata; // see (RULE1)
        end
    end

    // Read strobe answered one cycle later
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            io_rvalid_o <= 1'b0;
        end else begin
            io_rvalid_o <= io_req_i.rd; // see (RULE1)
        end
    end

    // Data holds until the next read; unmapped reads return zero
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            io_rdata_o <= 8'h00;
        end else if (io_req_i.rd) begin
            if (addr_hit[0]) begin
                io_rdata_o <= diagnostic_indicator_led_control; // see (RULE1)
            end else if (addr_hit[1]) begin
                io_rdata_o <= buzzer_control; // see (RULE1)
            end else if (addr_hit[2]) begin
                io_rdata_o <= user_led_bank; // see (RULE1)
            end else begin
                io_rdata_o <= 8'h00;
            end
        end
    end

    // Millisecond time base shared by both patterns; free running, so the first step may come early
    assign tick_due = (tick_cnt == `DLB_TICK_W'(`DLB_TICK_CYC - 1));

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tick_cnt <= '0;
        end else if (tick_due) begin
            tick_cnt <= '0;
        end else begin
            tick_cnt <= tick_cnt + 1'b1;
        end
    end

    // One-cycle enable pulse, the only rate below the system clock
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tick <= 1'b0;
        end else begin
            tick <= tick_due; // see (RULE7)
        end
    end

    // Only a 0 to 1 enable write restarts; a pattern change keeps the phase
    assign diagnostic_indicator_restart = wr_diagnostic_indicator && io_req_i.wdata[`DLB_BIT_EN] && !diagnostic_indicator_led_control[`DLB_BIT_EN]; // see (RULE7)
    assign buzz_restart = wr_buzz && io_req_i.wdata[`DLB_BIT_EN] && !buzzer_control[`DLB_BIT_EN]; // see (RULE7)
    assign diagnostic_indicator_shape   = lamp_shape(diagnostic_indicator_led_control[`DLB_BIT_PAT_HI:`DLB_BIT_PAT_LO]); // see (RULE3)
    assign buzz_shape   = beep_shape(buzzer_control[`DLB_BIT_PAT_HI:`DLB_BIT_PAT_LO]); // see (RULE5)

    // Phase wraps at the period; steady patterns sit at zero
    always_comb begin
        next_diagnostic_indicator_phase = diagnostic_indicator_phase;
        if (tick) begin
            next_diagnostic_indicator_phase = (diagnostic_indicator_phase + 1'b1 >= diagnostic_indicator_shape.period) ? '0 : diagnostic_indicator_phase + 1'b1;
        end
    end

    always_comb begin
        next_buzz_phase = buzz_phase;
        if (tick) begin
            next_buzz_phase = (buzz_phase + 1'b1 >= buzz_shape.period) ? '0 : buzz_phase + 1'b1;
        end
    end

    // Disabling clears the phase so the next enable starts in the on part
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            diagnostic_indicator_phase <= '0;
        end else if (diagnostic_indicator_restart || !diagnostic_indicator_led_control[`DLB_BIT_EN]) begin
            diagnostic_indicator_phase <= '0; // see (RULE7)
        end else begin
            diagnostic_indicator_phase <= next_diagnostic_indicator_phase;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            buzz_phase <= '0;
        end else if (buzz_restart || !buzzer_control[`DLB_BIT_EN]) begin
            buzz_phase <= '0; // see (RULE7)
        end else begin
            buzz_phase <= next_buzz_phase;
        end
    end

    // Drive levels ahead of the output flops
    assign next_diagnostic_indicator = diagnostic_indicator_led_control[`DLB_BIT_EN] && shape_out(diagnostic_indicator_shape, diagnostic_indicator_phase); // see (RULE2)
    assign next_buzz = buzzer_control[`DLB_BIT_EN] && shape_out(buzz_shape, buzz_phase); // see (RULE4)

    // Outputs registered so pins never glitch on decode
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ind_o <= '0;
        end else begin
            ind_o.diagnostic_indicator_lamp      <= next_diagnostic_indicator;
            ind_o.buzzer         <= next_buzz;
            ind_o.user_lamp_bits <= user_led_bank; // see (RULE6)
        end
    end
endmodule : dlb_ctrl
`default_nettype wire

// *** dlb_load_model.sv ***
// Load model for the lamps and buzzer: counts the cycles the buzzer sounds.
// Assumes the controller's indicator struct and its reset.
`timescale 1ns/1ps
`default_nettype none
module dlb_load_model (
    input  wire logic              sys_clk_i,
    input  wire logic              rst_i,
    input  wire dlb_pkg::dlb_ind_t ind_i,
    output var  logic [15:0]       buzz_cyc_o
);
    import dlb_pkg::*;
    // Sounding time is what a listener notices, so only that is kept
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) buzz_cyc_o <= 16'h0000;
        else if (ind_i.buzzer) buzz_cyc_o <= buzz_cyc_o + 16'h0001;
    end
endmodule : dlb_load_model
`default_nettype wire

// *** dlb_ctrl_assertions.sv ***
// Port checks on the indicator controller.
// Assumes a bind onto dlb_ctrl; one clock, async reset.
`timescale 1ns/1ps
`default_nettype none
`include "dlb_defines.svh"
module dlb_ctrl_chk (
    input wire logic                 sys_clk_i,
    input wire logic                 rst_i,
    input wire dlb_pkg::dlb_io_req_t io_req_i,
    input wire logic [7:0]           io_rdata_o,
    input wire logic                 io_rvalid_o,
    input wire dlb_pkg::dlb_ind_t    ind_o
);
    import dlb_pkg::*;
    logic de;
    logic be;
    wire [9:0] ad = io_req_i.addr;
    wire       en = io_req_i.wdata[0];
    wire       wd = io_req_i.wr && ad == `DLB_OFS_DIAGNOSTIC_INDICATOR;
    wire       wb = io_req_i.wr && ad == `DLB_OFS_BUZZ;
    wire       wu = io_req_i.wr && ad == `DLB_OFS_ULED;
    wire       rc = io_req_i.rd && (ad == `DLB_OFS_DIAGNOSTIC_INDICATOR || ad == `DLB_OFS_BUZZ);
    wire       ru = io_req_i.rd && !rc && ad != `DLB_OFS_ULED;
    // Only a 0 to 1 enable restarts the phase, so track the stored enables
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) {de, be} <= 2'b00;
        else {de, be} <= {wd ? en : de, wb ? en : be};
    end
    default clocking @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);
    a_read_answer: assert property (io_req_i.rd |=> io_rvalid_o) else $error("read unanswered");
    a_unmapped_zero: assert property (ru |=> io_rdata_o == 8'h00) else $error("unmapped read");
    a_reserved_zero: assert property (rc |=> io_rdata_o[7:3] == 5'h00) else $error("reserved set");
    a_user_direct: assert property (wu |-> ##2 ind_o.user_lamp_bits == $past(io_req_i.wdata, 2))
        else $error("user lamps");
    a_diagnostic_indicator_off: assert property (wd && !en |-> ##2 !ind_o.diagnostic_indicator_lamp) else $error("lamp lit");
    a_diagnostic_indicator_on: assert property (wd && en && !de |-> ##2 ind_o.diagnostic_indicator_lamp) else $error("lamp dark");
    a_buzz_off: assert property (wb && !en |-> ##2 !ind_o.buzzer) else $error("buzzer on");
    a_buzz_on: assert property (wb && en && !be |-> ##2 ind_o.buzzer) else $error("buzzer off");
    c_diagnostic_indicator_on: cover property (wd && en);
    c_buzz_on: cover property (wb && en);
    c_unmapped: cover property (ru);
endmodule : dlb_ctrl_chk
bind dlb_ctrl dlb_ctrl_chk chk_u (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .io_req_i(io_req_i),
    .io_rdata_o(io_rdata_o), .io_rvalid_o(io_rvalid_o), .ind_o(ind_o));
`default_nettype wire

// *** diagnostic_indicator_led_buzzer_ctrl_tb.sv ***
// Self-checking bench: registers, lamp, buzzer and user lamps of dlb_ctrl.
// Assumes dlb_ctrl, dlb_load_model and the bound checker compiled ahead.
`timescale 1ns/1ps
`default_nettype none
`include "dlb_defines.svh"
module diagnostic_indicator_led_buzzer_ctrl_tb;
    import dlb_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    dlb_io_req_t req = '0;
    logic [7:0]  rdata;
    logic        rvalid;
    dlb_ind_t    ind;
    logic [15:0] buzz_cyc;
    int          miscompares = 0;
    int          checks = 0;
    int          cyc = 0;
    dlb_ctrl dut_u (.sys_clk_i(clk), .rst_i(rst), .io_req_i(req), .io_rdata_o(rdata), .io_rvalid_o(rvalid),
                    .ind_o(ind));
    dlb_load_model load_u (.sys_clk_i(clk), .rst_i(rst), .ind_i(ind), .buzz_cyc_o(buzz_cyc));
    always #5 clk = ~clk;
    task automatic summarize();
        if (miscompares == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : summarize
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            miscompares++;
            summarize();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [9:0] ad, input logic [7:0] d);
        @(posedge clk) req <= '{1'b1, 1'b0, ad, d};
        @(posedge clk) req <= '0;
    endtask : wr
    task automatic rd(input logic [9:0] ad, input logic [7:0] exp);
        @(posedge clk) req <= '{1'b0, 1'b1, ad, 8'h00};
        @(posedge clk) req <= '0;
        // The valid pulse stands for one cycle only, right after the taking edge
        #1 chk({7'h00, rvalid, rdata}, {8'h01, exp});
    endtask : rd
    task automatic look(input logic [9:0] exp);
        @(posedge clk) #1;
        chk({6'h00, ind}, {6'h00, exp});
    endtask : look
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        look(10'h000);
        rd(`DLB_OFS_DIAGNOSTIC_INDICATOR, 8'h00);
        rd(`DLB_OFS_BUZZ, 8'h00);
        rd(`DLB_OFS_ULED, 8'h00);
        wr(`DLB_OFS_BUZZ, 8'h01);
        repeat (48) @(posedge clk);
        wr(`DLB_OFS_BUZZ, 8'h00);
        repeat (3) @(posedge clk);
        #1 chk(buzz_cyc, 16'd50);
        // Periods outlast the run, so only the first on phase is seen
        for (int p = 0; p < 4; p++) begin
            wr(`DLB_OFS_DIAGNOSTIC_INDICATOR, {5'h00, p[1:0], 1'b0});
            look(10'h000);
            wr(`DLB_OFS_DIAGNOSTIC_INDICATOR, {5'h1F, p[1:0], 1'b1});
            look(10'h200);
            rd(`DLB_OFS_DIAGNOSTIC_INDICATOR, {5'h00, p[1:0], 1'b1});
            wr(`DLB_OFS_DIAGNOSTIC_INDICATOR, 8'h00);
            look(10'h000);
            wr(`DLB_OFS_BUZZ, {5'h00, p[1:0], 1'b0});
            look(10'h000);
            wr(`DLB_OFS_BUZZ, {5'h1F, p[1:0], 1'b1});
            look(10'h100);
            rd(`DLB_OFS_BUZZ, {5'h00, p[1:0], 1'b1});
            wr(`DLB_OFS_BUZZ, 8'h00);
            look(10'h000);
        end
        wr(`DLB_OFS_ULED, 8'hA5);
        look(10'h0A5);
        rd(`DLB_OFS_ULED, 8'hA5);
        wr(`DLB_OFS_ULED, 8'h5A);
        wr(10'h212, 8'hFF);
        rd(10'h212, 8'h00);
        rd(`DLB_OFS_DIAGNOSTIC_INDICATOR, 8'h00);
        look(10'h05A);
        // Mid-run reset must drop a lit lamp and the user bank back to zero
        wr(`DLB_OFS_DIAGNOSTIC_INDICATOR, 8'h01);
        look(10'h25A);
        @(posedge clk) rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        look(10'h000);
        rd(`DLB_OFS_ULED, 8'h00);
        rd(`DLB_OFS_DIAGNOSTIC_INDICATOR, 8'h00);
        summarize();
    end
endmodule : diagnostic_indicator_led_buzzer_ctrl_tb
`default_nettype wire
